/* src/irq_vector_priority_map.sv */
`include "irq_vec_map.svh"
// Contract
// - There are 24 requests, 0..23, each with its own 2-bit level.
// - Among equal-level pending requests the lowest number wins.
// - Request n vectors through upper byte FFFA-2n, lower byte next.
// - Full variants: ch4->0, ch5->1, ch2/ch6->2, ch3/ch7->3.
// - Timer 0 lower half raises 5, upper half 6, on every variant.
// - First variant only: timer 1 upper raises 14, lower raises 22.
// - Reduced variant wires only ext 4/6, timer 0, ADC, TBT, WPS, flash.
module irq_vector_priority_map
   import irq_vec_pkg::*;
#(
   parameter irq_vec_pkg::variant_t VARIANT = irq_vec_pkg::VAR_FULL_A,
   parameter int NREQ = `IRQ_COUNT
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // External interrupt pins 2..7 (index = channel), asynchronous
   input  wire logic [7:0]  extIrq,
   // On-chip sources, same clock
   input  wire logic        tmr0LoIrq,
   input  wire logic        tmr0HiIrq,
   input  wire logic        tmr1LoIrq,
   input  wire logic        tmr1HiIrq,
   input  wire logic        uartRxIrq,
   input  wire logic        uartTxIrq,
   input  wire logic        adcIrq,
   input  wire logic        tbtIrq,
   input  wire logic        wpsIrq,
   input  wire logic        flashIrq,
   // Level fields, packed: request n at [2n+1:2n]
   input  wire logic [47:0] levelFields,
   // Selection toward the core
   output logic             irqValid,
   output logic [4:0]       irqNum,
   output logic [1:0]       irqLevel,
   output logic [15:0]      vecUpperAddr,
   output logic [15:0]      vecLowerAddr
);
   import irq_vec_pkg::*;

   typedef struct packed {
      logic [7:0]  syncA;
      logic [7:0]  syncB;
      logic [7:0]  syncC;
      logic [7:0]  extLvl;
      logic        valid;
      logic [4:0]  num;
      logic [1:0]  level;
      logic [15:0] vecHi;
      logic [15:0] vecLo;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [23:0] reqLines;
   logic        found;
   logic [4:0]  bestNum;
   logic [1:0]  bestLvl;
   logic [15:0] vecAddr;

   // Pin-side events enter through the filtered synchroniser
   irq_source_map #(.VARIANT(VARIANT)) irq_source_map_inst (
      .extIrq    (st_r.extLvl),
      .tmr0LoIrq (tmr0LoIrq),
      .tmr0HiIrq (tmr0HiIrq),
      .tmr1LoIrq (tmr1LoIrq),
      .tmr1HiIrq (tmr1HiIrq),
      .uartRxIrq (uartRxIrq),
      .uartTxIrq (uartTxIrq),
      .adcIrq    (adcIrq),
      .tbtIrq    (tbtIrq),
      .wpsIrq    (wpsIrq),
      .flashIrq  (flashIrq),
      .reqLines  (reqLines)
   );

   // Level 0 is most urgent; scanning downward with <= makes the
   // lowest-numbered request win a tie
   always_comb begin
      found   = 1'b0;
      bestNum = 5'h00;
      bestLvl = `IRQ_LEVEL_RST;
      for (int i = NREQ - 1; i >= 0; i--) begin
         if (reqLines[i] &&
             (!found || levelFields[2*i +: 2] <= bestLvl)) begin
            found   = 1'b1;
            bestNum = 5'(i);
            bestLvl = levelFields[2*i +: 2];
         end
      end
      vecAddr = `IRQ_VEC_BASE - {10'h000, bestNum, 1'b0};
   end

   // Next state; a pin level changes only when stages B and C agree
   always_comb begin
      st_nxt       = st_r;
      st_nxt.syncA = extIrq;
      st_nxt.syncB = st_r.syncA;
      st_nxt.syncC = st_r.syncB;
      for (int c = 0; c < 8; c++) begin
         if (st_r.syncB[c] == st_r.syncC[c])
            st_nxt.extLvl[c] = st_r.syncC[c];
      end
      st_nxt.valid = found;
      st_nxt.num   = found ? bestNum : 5'h00;
      st_nxt.level = found ? bestLvl : `IRQ_LEVEL_RST;
      st_nxt.vecHi = found ? vecAddr : 16'h0000;
      st_nxt.vecLo = found ? vecAddr + `IRQ_VEC_STEP / 2 : 16'h0000;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_r       <= '0;
         st_r.level <= `IRQ_LEVEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign irqValid     = st_r.valid;
   assign irqNum       = st_r.num;
   assign irqLevel     = st_r.level;
   assign vecUpperAddr = st_r.vecHi;
   assign vecLowerAddr = st_r.vecLo;

   // Checks
   property p_vec_addr;
      @(posedge clock) disable iff (rst)
      irqValid |-> vecUpperAddr == 16'hfffa - {10'h000, irqNum, 1'b0}
                   && vecLowerAddr == vecUpperAddr + 16'h0001;
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector address does not match request number");

   property p_tie_low;
      @(posedge clock) disable iff (rst)
      (reqLines[0] && levelFields[1:0] == 2'h0)
         |=> irqValid && irqNum == 5'h00;
   endproperty
   a_tie_low: assert property (p_tie_low)
      else $error("request 0 at top level not chosen");

   property p_no_req;
      @(posedge clock) disable iff (rst)
      (reqLines == 24'h000000) |=> !irqValid;
   endproperty
   a_no_req: assert property (p_no_req)
      else $error("selection with no pending request");

   property p_sel_pending;
      @(posedge clock) disable iff (rst)
      // Index the previous request vector with the current selection
      irqValid |-> ($past(reqLines) & (24'h000001 << irqNum)) != 24'h000000
                   && irqNum < 5'd24;
   endproperty
   a_sel_pending: assert property (p_sel_pending)
      else $error("selected request was not pending");

   property p_unused4;
      @(posedge clock) disable iff (rst)
      irqValid |-> irqNum != 5'h04 && irqNum != 5'h09;
   endproperty
   a_unused4: assert property (p_unused4)
      else $error("unassigned request selected");

   property p_tmr0;
      @(posedge clock) disable iff (rst)
      (tmr0LoIrq && !tmr0HiIrq && levelFields[11:10] == 2'h0
       && reqLines[4:0] == 5'h00) |=> irqNum == 5'h05;
   endproperty
   a_tmr0: assert property (p_tmr0)
      else $error("timer 0 lower half not on request 5");

   property p_flash;
      @(posedge clock) disable iff (rst)
      (reqLines == 24'h800000 && flashIrq) |=> irqValid ##0 irqNum == 5'h17;
   endproperty
   a_flash: assert property (p_flash)
      else $error("flash not on request 23");

   property p_ext4;
      @(posedge clock) disable iff (rst)
      (st_r.extLvl[4] && levelFields[1:0] == 2'h0) |=> irqNum == 5'h00;
   endproperty
   a_ext4: assert property (p_ext4)
      else $error("external channel 4 not on request 0");

   property p_tmr1;
      @(posedge clock) disable iff (rst)
      (VARIANT != VAR_FULL_A) |-> !reqLines[14] && !reqLines[22];
   endproperty
   a_tmr1: assert property (p_tmr1)
      else $error("timer 1 request on a variant without it");
endmodule : irq_vector_priority_map

/* shared/irq_vec_map.svh */
`ifndef IRQ_VEC_MAP_SVH
`define IRQ_VEC_MAP_SVH
// Request count and vector table layout
`define IRQ_COUNT       24
`define IRQ_LEVEL_W     2
`define IRQ_NUM_W       5
`define IRQ_VEC_BASE    16'hfffa
`define IRQ_VEC_STEP    16'h0002
// Level reset value (lowest priority level)
`define IRQ_LEVEL_RST   2'h3
// Request numbers of fixed sources
`define IRQ_EXT4        5'h00
`define IRQ_EXT5        5'h01
`define IRQ_EXT26       5'h02
`define IRQ_EXT37       5'h03
`define IRQ_TMR0_LO     5'h05
`define IRQ_TMR0_HI     5'h06
`define IRQ_UART_RX     5'h07
`define IRQ_UART_TX     5'h08
`define IRQ_TMR1_HI     5'h0e
`define IRQ_ADC         5'h12
`define IRQ_TBT         5'h13
`define IRQ_WPS         5'h14
`define IRQ_TMR1_LO     5'h16
`define IRQ_FLASH       5'h17
`endif

/* shared/irq_vec_pkg.sv */
package irq_vec_pkg;
   // Product variant, selects which request lines are populated
   typedef enum logic [1:0] {
      VAR_FULL_A = 2'h0,
      VAR_REDUCED = 2'h1,
      VAR_FULL_B = 2'h2
   } variant_t;
endpackage : irq_vec_pkg

/* src/irq_source_map.sv */
`include "irq_vec_map.svh"
// Routes peripheral event lines onto request numbers per variant
module irq_source_map
   import irq_vec_pkg::*;
#(
   parameter irq_vec_pkg::variant_t VARIANT = irq_vec_pkg::VAR_FULL_A
) (
   // External interrupt channels 2..7 (index = channel)
   input  wire logic [7:0]  extIrq,
   // On-chip sources
   input  wire logic        tmr0LoIrq,
   input  wire logic        tmr0HiIrq,
   input  wire logic        tmr1LoIrq,
   input  wire logic        tmr1HiIrq,
   input  wire logic        uartRxIrq,
   input  wire logic        uartTxIrq,
   input  wire logic        adcIrq,
   input  wire logic        tbtIrq,
   input  wire logic        wpsIrq,
   input  wire logic        flashIrq,
   // Request lines
   output logic [23:0]      reqLines
);
   localparam bit FULL = (VARIANT != VAR_REDUCED);

   // Unassigned request numbers stay zero on every variant
   always_comb begin
      reqLines = 24'h000000;
      reqLines[`IRQ_EXT4]    = extIrq[4];
      reqLines[`IRQ_EXT26]   = extIrq[6] | (FULL & extIrq[2]);
      reqLines[`IRQ_TMR0_LO] = tmr0LoIrq;
      reqLines[`IRQ_TMR0_HI] = tmr0HiIrq;
      reqLines[`IRQ_ADC]     = adcIrq;
      reqLines[`IRQ_TBT]     = tbtIrq;
      reqLines[`IRQ_WPS]     = wpsIrq;
      reqLines[`IRQ_FLASH]   = flashIrq;
      if (FULL) begin
         reqLines[`IRQ_EXT5]    = extIrq[5];
         reqLines[`IRQ_EXT37]   = extIrq[3] | extIrq[7];
         reqLines[`IRQ_UART_RX] = uartRxIrq;
         reqLines[`IRQ_UART_TX] = uartTxIrq;
      end
      if (VARIANT == VAR_FULL_A) begin
         reqLines[`IRQ_TMR1_HI] = tmr1HiIrq;
         reqLines[`IRQ_TMR1_LO] = tmr1LoIrq;
      end
   end
endmodule : irq_source_map

/* sim/vec_fetch_model.sv */
// Stand-in for the core: latches the vector pair while one is offered
module vec_fetch_model (
   // Clock
   input  wire logic        clock,
   // Selection from the controller
   input  wire logic        irqValid,
   input  wire logic [15:0] vecUpperAddr,
   input  wire logic [15:0] vecLowerAddr,
   // Last vector pair fetched
   output logic      [15:0] fetchUpper,
   output logic      [15:0] fetchLower
);
   timeunit 1ns;
   timeprecision 1ps;
   // The core only fetches when offered, so stale pairs stay visible
   always_ff @(posedge clock) begin
      if (irqValid) begin
         fetchUpper <= vecUpperAddr;
         fetchLower <= vecLowerAddr;
      end
   end
endmodule : vec_fetch_model

/* sim/tb_irq_vector_priority_map.sv */
module tb_irq_vector_priority_map import irq_vec_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock;
   logic        rst;
   logic [17:0] src;
   logic [47:0] lvl;
   logic        irqValid;
   logic [4:0]  irqNum;
   logic [1:0]  irqLevel;
   logic [15:0] vecUp;
   logic [15:0] vecLo;
   logic [15:0] fUp;
   logic [15:0] fLo;
   int          fails;
   int          n_compared;
   int          cyc;
   // Request expected per source bit; bits 10 and 11 are ext ch0/1
   int reqOf [18] = '{23, 20, 19, 18, 8, 7, 14, 22, 6, 5,
                      31, 31, 2, 3, 0, 1, 2, 3};

   irq_vector_priority_map #(
      .VARIANT(VAR_FULL_A)
   ) irq_vector_priority_map_inst (
      .clock(clock), .rst(rst), .extIrq(src[17:10]),
      .tmr0LoIrq(src[9]), .tmr0HiIrq(src[8]), .tmr1LoIrq(src[7]),
      .tmr1HiIrq(src[6]), .uartRxIrq(src[5]), .uartTxIrq(src[4]),
      .adcIrq(src[3]), .tbtIrq(src[2]), .wpsIrq(src[1]),
      .flashIrq(src[0]), .levelFields(lvl), .irqValid(irqValid),
      .irqNum(irqNum), .irqLevel(irqLevel), .vecUpperAddr(vecUp),
      .vecLowerAddr(vecLo));

   vec_fetch_model vec_fetch_model_inst (
      .clock(clock), .irqValid(irqValid), .vecUpperAddr(vecUp),
      .vecLowerAddr(vecLo), .fetchUpper(fUp), .fetchLower(fLo));

   // Free-running clock, 4 ns period
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic apply(logic [17:0] s, logic [47:0] l);
      @(posedge clock);
      src <= s;
      lvl <= l;
   endtask : apply

   // Drop all requests; the ext filter needs a few edges to drain
   task automatic quiet();
      apply('0, '1);
      repeat (6) @(posedge clock);
   endtask : quiet

   task automatic expect_req(int n, logic [1:0] lv);
      // Fixed wait: pin requests arrive later than same-clock ones,
      // so the first valid cycle may not show the final winner
      repeat (6) @(posedge clock);
      #1;
      chk("valid", 16'(irqValid), 16'h0001);
      chk("num", 16'(irqNum), 16'(n));
      chk("level", 16'(irqLevel), 16'(lv));
      chk("upper", vecUp, 16'hfffa - 16'(2 * n));
      chk("lower", vecLo, 16'hfffb - 16'(2 * n));
      @(posedge clock);
      #1;
      chk("fetched", fUp, 16'hfffa - 16'(2 * n));
      quiet();
   endtask : expect_req

   task automatic s_reset();
      #1;
      chk("rstValid", 16'(irqValid), 16'h0000);
      chk("rstLevel", 16'(irqLevel), 16'h0003);
      chk("rstUpper", vecUp, 16'h0000);
   endtask : s_reset

   // Every populated source alone at level 0
   task automatic s_each();
      for (int i = 0; i < 18; i++) begin
         if (reqOf[i] != 31) begin
            apply(18'(1) << i, '0);
            expect_req(reqOf[i], 2'h0);
         end
      end
   endtask : s_each

   // Unwired ext channels must never produce a request
   task automatic s_unused();
      apply(18'h00c00, '0);
      repeat (8) @(posedge clock);
      #1;
      chk("unused", 16'(irqValid), 16'h0000);
      quiet();
   endtask : s_unused

   // Ties go to the lowest number; a more urgent level beats rank
   task automatic s_tie();
      apply('1, '0);
      expect_req(0, 2'h0);
      apply('1, 48'h0000_0000_00ff);
      expect_req(5, 2'h0);
      apply('1, 48'hbfff_ffff_ffff);
      expect_req(23, 2'h2);
   endtask : s_tie

   task automatic end_of_test();
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      src = '0;
      lvl = '1;
      fails = 0;
      n_compared = 0;
      cyc = 0;
      repeat (5) @(posedge clock);
      s_reset();
      @(posedge clock);
      rst <= 1'b0;
      s_each();
      s_unused();
      s_tie();
      end_of_test();
   end
endmodule : tb_irq_vector_priority_map
